// [common/pwio_pkg.sv]
package pwio_pkg;

   localparam int LINE_W = 16;
   localparam int AV_ADDR_W = 6;

   // byte addresses of the register words
   localparam logic [AV_ADDR_W-1:0] REG_INPUT = 6'h00;
   localparam logic [AV_ADDR_W-1:0] REG_OUTPUT = 6'h04;
   localparam logic [AV_ADDR_W-1:0] REG_STATUS = 6'h08;
   localparam logic [AV_ADDR_W-1:0] REG_MODE = 6'h0C;
   localparam logic [AV_ADDR_W-1:0] REG_DUAL = 6'h10;
   localparam logic [AV_ADDR_W-1:0] REG_BITIE = 6'h14;
   localparam logic [AV_ADDR_W-1:0] REG_CONN = 6'h18;
   localparam logic [AV_ADDR_W-1:0] REG_IRQ_STAT = 6'h1C;
   localparam logic [AV_ADDR_W-1:0] REG_IRQ_MASK = 6'h20;

   // status register fields
   localparam int STAT_IE_BIT = 14;
   localparam int STAT_REQ_BIT = 7;

   // sticky event bits
   localparam int IRQ_W = 2;
   localparam int IRQ_IN_BIT = 0;
   localparam int IRQ_OUT_BIT = 1;

   // reset values
   localparam logic [LINE_W-1:0] OUTPUT_RST = 16'h0000;
   localparam logic [LINE_W-1:0] MODE_RST = 16'h0000;
   localparam logic [LINE_W-1:0] DUAL_RST = 16'h0000;
   localparam logic [LINE_W-1:0] BITIE_RST = 16'h0000;
   localparam logic [LINE_W-1:0] CONN_RST = 16'hFFFF;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

   // avalon request bundle from the master
   typedef struct packed {
      logic [AV_ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } pwio_av_req_t;

endpackage

// [rtl/pwio_top.sv]
`timescale 1ns/1ps
`default_nettype none

// Function
// [RL1] unconnected input lines are forced so software reads them as zero; in register mode the code returns the latch, which conn does not mask
// [RL2] direct-mode input bits read the present line level, unlatched
// [RL3] register-mode input bits are set by a falling line transition
// [RL4] a latched bit stays set until software clears it
// [RL5] with interrupt enable on, a latched enabled bit requests an interrupt
// [RL6] register-mode latched bits are readable through the input register
// [RL7] bits 15:12 may latch on either edge and then interrupt
// [RL8] writing ones to the input register clears those latched bits, e.g. 15:12
// [RL9] writing bit 14 of the status register sets the input interrupt enable
// [RL10] software waits about 50 ms after an edge interrupt before reading data
// [RL11] output lines match input lines so two ports can be cross-connected
// [RL12] output register is written as two independent bytes with own load strobes
// [RL13] a word written out and looped back reads back unchanged
// [RL14] request holds while enable and a capable latched bit are set; the code also needs that bit's bitie enable set
module pwio_top #(
   parameter int DUAL_LO = 12, // lowest dual-edge capable bit
   parameter int DUAL_HI = 15  // highest dual-edge capable bit
) (
   input wire logic CLK_I, // 125 MHz clock
   input wire logic RSTN_I, // async reset, active low
   input wire pwio_pkg::pwio_av_req_t AV_REQ_I, // avalon request bundle
   output logic [31:0] AV_READDATA_O, // avalon read data
   output logic AV_WAITREQUEST_O, // avalon wait request
   input wire logic [pwio_pkg::LINE_W-1:0] IN_LINE_I, // external input lines
   output logic [pwio_pkg::LINE_W-1:0] OUT_LINE_O, // external output lines
   output logic [1:0] OUT_LOAD_O, // per byte load strobe
   output logic IN_REQ_O, // input interrupt request level
   output logic IRQ_O // masked sticky interrupt
);
   import pwio_pkg::*;

   if (DUAL_LO < 0 || DUAL_HI >= LINE_W || DUAL_LO > DUAL_HI) begin : g_bad_dual
      $error("pwio_top: dual-edge bit range out of the line width");
   end

   function automatic logic [LINE_W-1:0] dual_span(input int lo, input int hi);
      logic [LINE_W-1:0] m;
      m = '0;
      for (int i = 0; i < LINE_W; i++) begin
         if (i >= lo && i <= hi) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   function automatic logic [LINE_W-1:0] merge16(input logic [LINE_W-1:0] old,
                                                  input logic [31:0] wd,
                                                  input logic [3:0] be);
      logic [LINE_W-1:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   localparam logic [LINE_W-1:0] DUAL_OK = dual_span(DUAL_LO, DUAL_HI);

   ////////////////////////////////////////////////////////////////////////////
   // reset release

   logic rst_meta;
   logic rst_n;

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle on every access

   logic ack;
   logic req;
   logic wr_go;
   logic [31:0] wd;
   logic [3:0] be;
   logic [AV_ADDR_W-1:0] adr;

   assign req = AV_REQ_I.read | AV_REQ_I.write;
   assign wr_go = AV_REQ_I.write & ack;
   assign wd = AV_REQ_I.writedata;
   assign be = AV_REQ_I.byteenable;
   assign adr = {AV_REQ_I.address[AV_ADDR_W-1:2], 2'b00};
   assign AV_WAITREQUEST_O = req & ~ack;

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers

   logic [LINE_W-1:0] mode;
   logic [LINE_W-1:0] dual;
   logic [LINE_W-1:0] bitie;
   logic [LINE_W-1:0] conn;
   logic ie;

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         mode <= MODE_RST;
         dual <= DUAL_RST;
         bitie <= BITIE_RST;
         conn <= CONN_RST;
      end else if (wr_go) begin
         if (adr == REG_MODE) begin
            mode <= merge16(mode, wd, be);
         end
         if (adr == REG_DUAL) begin
            dual <= merge16(dual, wd, be) & DUAL_OK; // [RL7]
         end
         if (adr == REG_BITIE) begin
            bitie <= merge16(bitie, wd, be);
         end
         if (adr == REG_CONN) begin
            conn <= merge16(conn, wd, be);
         end
      end
   end

   // the enable is a plain read/write bit so a handler can re-arm it
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         ie <= 1'b0;
      end else if (wr_go && adr == REG_STATUS && be[1]) begin
         ie <= wd[STAT_IE_BIT]; // [RL9]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input lines and edge latches

   logic [LINE_W-1:0] line;
   logic [LINE_W-1:0] prev;
   logic primed;
   logic [LINE_W-1:0] fall;
   logic [LINE_W-1:0] rise;
   logic [LINE_W-1:0] capable;
   logic [LINE_W-1:0] set_ev;
   logic [LINE_W-1:0] clr;
   logic [LINE_W-1:0] latch;
   logic [LINE_W-1:0] next_latch;
   logic [LINE_W-1:0] rd_input;

   assign line = IN_LINE_I & conn; // [RL1]
   assign fall = prev & ~line;
   assign rise = ~prev & line;
   assign capable = mode | (dual & DUAL_OK);
   // no edges until one line sample is held, so reset levels never count
   assign set_ev = primed ? ((mode & fall) | (dual & DUAL_OK & (fall | rise))) : '0; // [RL3] [RL7]
   assign clr = (wr_go && adr == REG_INPUT) ? merge16('0, wd, be) : '0; // [RL8]
   assign next_latch = (latch & ~clr) | set_ev; // [RL4]
   assign rd_input = (latch & mode) | (line & ~mode); // [RL2] [RL6] [RL13]

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         prev <= '0;
         primed <= 1'b0;
      end else begin
         prev <= line;
         primed <= 1'b1;
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         latch <= '0;
      end else begin
         latch <= next_latch; // [RL4]
      end
   end

   assign IN_REQ_O = ie & |(latch & capable & bitie); // [RL5] [RL14]

   ////////////////////////////////////////////////////////////////////////////
   // output register: same width and polarity as the inputs

   logic [LINE_W-1:0] out_reg;
   logic [1:0] load;

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         out_reg <= OUTPUT_RST;
         load <= 2'h0;
      end else begin
         load <= 2'h0;
         if (wr_go && adr == REG_OUTPUT) begin
            out_reg <= merge16(out_reg, wd, be); // [RL12]
            load <= be[1:0]; // [RL12]
         end
      end
   end

   assign OUT_LINE_O = out_reg; // [RL11]
   assign OUT_LOAD_O = load;

   ////////////////////////////////////////////////////////////////////////////
   // sticky interrupt status, write one to clear, set wins

   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_ev;
   logic [IRQ_W-1:0] irq_clr;

   always_comb begin
      irq_ev = '0;
      irq_ev[IRQ_IN_BIT] = IN_REQ_O;
      irq_ev[IRQ_OUT_BIT] = |load;
   end

   assign irq_clr = (wr_go && adr == REG_IRQ_STAT && be[0]) ? wd[IRQ_W-1:0] : '0;

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= IRQ_MASK_RST;
      end else if (wr_go && adr == REG_IRQ_MASK && be[0]) begin
         irq_mask <= wd[IRQ_W-1:0];
      end
   end

   assign IRQ_O = |(irq_stat & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // read data, captured in the wait cycle and held through the answer

   logic [31:0] next_rdata;
   logic [31:0] rdata;

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (adr)
         REG_INPUT: next_rdata[LINE_W-1:0] = rd_input; // [RL6]
         REG_OUTPUT: next_rdata[LINE_W-1:0] = out_reg;
         REG_STATUS: begin
            next_rdata[STAT_IE_BIT] = ie;
            next_rdata[STAT_REQ_BIT] = IN_REQ_O;
         end
         REG_MODE: next_rdata[LINE_W-1:0] = mode;
         REG_DUAL: next_rdata[LINE_W-1:0] = dual;
         REG_BITIE: next_rdata[LINE_W-1:0] = bitie;
         REG_CONN: next_rdata[LINE_W-1:0] = conn;
         REG_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
         REG_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else if (AV_REQ_I.read && !ack) begin
         rdata <= next_rdata;
      end
   end

   assign AV_READDATA_O = rdata;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   // the read checks except a_direct_level look at the captured word, so the capture path is covered too
   a_unconn_zero: assert property (@(posedge CLK_I) disable iff (!rst_n) // [RL1]
      (AV_REQ_I.read && !ack && adr == REG_INPUT)
      |=> ((AV_READDATA_O[LINE_W-1:0] & $past(~conn & ~mode)) == '0))
      else $error("unconnected direct bit reads nonzero");

   a_direct_level: assert property (@(posedge CLK_I) disable iff (!rst_n) // [RL2]
      ((rd_input ^ IN_LINE_I) & ~mode & conn) == '0)
      else $error("direct bit differs from its line");

   a_fall_sets: assert property (@(posedge CLK_I) disable iff (!rst_n) // [RL3]
      (primed && |(mode & prev & ~line))
      |=> ((latch & $past(mode & prev & ~line)) == $past(mode & prev & ~line)))
      else $error("falling edge did not set latch");

   a_latch_hold: assert property (@(posedge CLK_I) disable iff (!rst_n) // [RL4]
      !(wr_go && adr == REG_INPUT) |=> ((latch & $past(latch)) == $past(latch)))
      else $error("latched bit lost without a clear");

   a_latch_visible: assert property (@(posedge CLK_I) disable iff (!rst_n) // [RL6]
      (AV_REQ_I.read && !ack && adr == REG_INPUT)
      |=> ((AV_READDATA_O[LINE_W-1:0] & $past(latch & mode)) == $past(latch & mode)))
      else $error("latched input bit missing from read data");

   a_req_raise: assert property (@(posedge CLK_I) disable iff (!rst_n) // [RL5]
      (ie && !(wr_go && adr == REG_STATUS) && |(set_ev & bitie)) |=> IN_REQ_O ##1 irq_stat[IRQ_IN_BIT])
      else $error("enabled edge did not raise request and status");

   a_dual_edge: assert property (@(posedge CLK_I) disable iff (!rst_n) // [RL7]
      (primed && |(dual & DUAL_OK & (prev ^ line))) |=> |(latch & dual & DUAL_OK))
      else $error("dual-edge transition did not latch");

   a_top_clear: assert property (@(posedge CLK_I) disable iff (!rst_n) // [RL8]
      (wr_go && adr == REG_INPUT && be[1] && wd[15:12] == 4'hF && set_ev[15:12] == 4'h0)
      |=> latch[15:12] == 4'h0)
      else $error("clear of bits 15:12 failed");

   a_ie_write: assert property (@(posedge CLK_I) disable iff (!rst_n) // [RL9]
      (wr_go && adr == REG_STATUS && be[1] && wd[STAT_IE_BIT]) |=> ie)
      else $error("status write did not set enable");

   a_byte_split: assert property (@(posedge CLK_I) disable iff (!rst_n) // [RL12]
      (wr_go && adr == REG_OUTPUT && be[1:0] == 2'b01)
      |=> (OUT_LINE_O[15:8] == $past(OUT_LINE_O[15:8])) && OUT_LOAD_O == 2'b01)
      else $error("low byte write touched high byte");

   a_req_drop: assert property (@(posedge CLK_I) disable iff (!rst_n) // [RL14]
      (wr_go && adr == REG_INPUT && (clr & latch & capable) == (latch & capable) && set_ev == '0)
      |=> !IN_REQ_O)
      else $error("request stayed after its bits were cleared");

   // a clear that meets a new request must lose
   a_stat_set_wins: assert property (@(posedge CLK_I) disable iff (!rst_n)
      irq_ev[IRQ_IN_BIT] |=> irq_stat[IRQ_IN_BIT])
      else $error("input request did not set its sticky bit");

   a_bus_wait: assert property (@(posedge CLK_I) disable iff (!rst_n)
      (req && AV_WAITREQUEST_O) |=> !AV_WAITREQUEST_O)
      else $error("bus answer took more than one wait cycle");

endmodule

`default_nettype wire

// [testbench/pwio_ext_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module pwio_ext_dev (
   input wire logic loop_i, // 1: maintenance cable fitted
   input wire logic [15:0] word_i, // word the device presents
   input wire logic [15:0] out_line_i, // port output lines
   output logic [15:0] in_line_o // port input lines
);
   // the device holds its word steady between changes, so no strobe line is modelled
   assign in_line_o = loop_i ? out_line_i : word_i;
endmodule
`default_nettype wire

// [testbench/pwio_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module pwio_top_bench;
   import pwio_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   pwio_av_req_t req = '0;
   logic [31:0] rdata;
   logic wait_req;
   logic [15:0] in_line, out_line;
   logic [15:0] ext_word = '0;
   logic [1:0] load;
   logic in_req, irq;
   logic loop = 1'b1;
   int fails = 0, checked = 0, loads0 = 0, loads1 = 0;
   logic [31:0] seed = 32'h1CDEF3C8;
   logic [15:0] m_mode = '0, m_dual = '0, m_bitie = '0, m_conn = 16'hFFFF, m_latch = '0, m_line = '0, m_out = '0;
   logic [1:0] m_stat = '0, m_mask = '0;
   logic m_ie = 1'b0;
   always #4 clk = ~clk;
   pwio_top i_pwio_top (.CLK_I(clk), .RSTN_I(rstn), .AV_REQ_I(req), .AV_READDATA_O(rdata),
      .AV_WAITREQUEST_O(wait_req), .IN_LINE_I(in_line), .OUT_LINE_O(out_line), .OUT_LOAD_O(load),
      .IN_REQ_O(in_req), .IRQ_O(irq));
   pwio_ext_dev i_pwio_ext_dev (.loop_i(loop), .word_i(ext_word), .out_line_i(out_line), .in_line_o(in_line));
   // load strobes are one-cycle pulses, so count them mid-cycle
   always @(negedge clk) begin
      loads0 += (load[0] === 1'b1);
      loads1 += (load[1] === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rnd();
      for (int k = 0; k < 16; k++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[15:0];
   endfunction
   function automatic logic inr();
      return m_ie & (|(m_latch & m_bitie & (m_mode | m_dual)));
   endfunction
   function automatic logic [31:0] exp_rd(input logic [5:0] a);
      case (a)
         REG_INPUT: return {16'h0, (m_latch & m_mode) | (m_line & m_conn & ~m_mode)};
         REG_OUTPUT: return {16'h0, m_out};
         REG_STATUS: return {17'h0, m_ie, 6'h0, inr(), 7'h0};
         REG_MODE: return {16'h0, m_mode};
         REG_DUAL: return {16'h0, m_dual};
         REG_BITIE: return {16'h0, m_bitie};
         REG_CONN: return {16'h0, m_conn};
         REG_IRQ_STAT: return {30'h0, m_stat};
         REG_IRQ_MASK: return {30'h0, m_mask};
         default: return 32'h0;
      endcase
   endfunction
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
      logic w;
      int n;
      n = 0;
      @(posedge clk);
      req.address <= a;
      req.read <= ~wr;
      req.write <= wr;
      req.writedata <= d;
      req.byteenable <= be;
      // waitrequest and read data are taken at the rising edge itself, before it updates them
      do begin
         @(posedge clk);
         w = wait_req;
         n++;
      end while (w !== 1'b0 && n < 20);
      q = rdata;
      if (w !== 1'b0) `CHK("waitrequest", 1'b0, w)
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be = 4'h3);
      logic [31:0] q;
      logic [15:0] mk, m;
      mk = {{8{be[1]}}, {8{be[0]}}};
      m = mk & d[15:0];
      xfer(1'b1, a, d, be, q);
      case (a)
         REG_INPUT: m_latch &= ~m;
         REG_OUTPUT: begin
            m_out = (m_out & ~mk) | m;
            m_stat[1] = 1'b1;
            if (loop) m_line = m_out;
         end
         REG_STATUS: if (be[1]) m_ie = d[14];
         REG_MODE: m_mode = (m_mode & ~mk) | m;
         REG_DUAL: m_dual = ((m_dual & ~mk) | m) & 16'hF000;
         REG_BITIE: m_bitie = (m_bitie & ~mk) | m;
         REG_CONN: m_conn = (m_conn & ~mk) | m;
         REG_IRQ_STAT: m_stat &= ~d[1:0];
         REG_IRQ_MASK: m_mask = d[1:0];
         default: ;
      endcase
      if (inr()) m_stat[0] = 1'b1;
   endtask
   task automatic rd_chk(input logic [5:0] a, input string nm);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, 4'hF, q);
      `CHK(nm, exp_rd(a), q)
      @(negedge clk);
      `CHK("in_req", inr(), in_req)
      `CHK("irq", |(m_stat & m_mask), irq)
      `CHK("out_line", m_out, out_line)
   endtask
   task automatic set_line(input logic [15:0] w, input logic lp);
      logic [15:0] o, n;
      // edges are seen only on connected lines
      o = m_line & m_conn;
      n = w & m_conn;
      m_latch |= ((o & ~n) & m_mode) | ((o ^ n) & m_dual);
      m_line = w;
      if (inr()) m_stat[0] = 1'b1;
      @(posedge clk);
      ext_word <= w;
      loop <= lp;
      repeat (3) @(posedge clk);
   endtask
   task automatic give_verdict;
      if (fails == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      give_verdict;
   end
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(REG_CONN, "conn");
      rd_chk(REG_STATUS, "status");
      rd_chk(REG_IRQ_MASK, "mask");
      wr(6'h3C, 32'h0000FFFF);
      rd_chk(6'h3C, "unmapped");
      for (int i = 0; i < 8; i++) begin
         wr(REG_OUTPUT, {16'h0, rnd()});
         rd_chk(REG_INPUT, "loopback");
      end
      wr(REG_OUTPUT, {16'h0, rnd()}, 4'h1);
      rd_chk(REG_OUTPUT, "low byte");
      wr(REG_OUTPUT, {16'h0, rnd()}, 4'h2);
      rd_chk(REG_INPUT, "high byte");
      `CHK("loads0", 9, loads0)
      `CHK("loads1", 9, loads1)
      rd_chk(REG_IRQ_STAT, "irq_stat");
      wr(REG_IRQ_MASK, 32'h2);
      rd_chk(REG_IRQ_STAT, "irq_stat");
      wr(REG_IRQ_STAT, 32'h2);
      rd_chk(REG_IRQ_STAT, "irq_stat");
      wr(REG_CONN, {16'h0, rnd()});
      for (int i = 0; i < 4; i++) begin
         set_line(rnd(), 1'b0);
         rd_chk(REG_INPUT, "direct");
      end
      wr(REG_MODE, 32'h0000FFFF);
      set_line(16'hFFFF, 1'b0);
      rd_chk(REG_INPUT, "latched");
      wr(REG_INPUT, 32'h0000FFFF);
      set_line(rnd(), 1'b0);
      rd_chk(REG_INPUT, "latched");
      set_line(16'hFFFF, 1'b0);
      set_line(rnd(), 1'b0);
      rd_chk(REG_INPUT, "held");
      wr(REG_INPUT, 32'h0000FFFF);
      rd_chk(REG_INPUT, "cleared");
      wr(REG_MODE, 32'h0);
      wr(REG_CONN, 32'h0000FFFF);
      wr(REG_DUAL, 32'h0000FFFF);
      wr(REG_BITIE, 32'h0000FFFF);
      rd_chk(REG_DUAL, "dual mask");
      rd_chk(REG_BITIE, "bit enable");
      wr(REG_IRQ_MASK, 32'h3);
      wr(REG_STATUS, 32'h00004000);
      rd_chk(REG_STATUS, "enable");
      for (int k = 0; k < 8; k++) begin
         set_line(m_line ^ (16'h1000 << (k % 4)), 1'b0);
         set_line(m_line ^ 16'h0100, 1'b0);
         rd_chk(REG_STATUS, "dual edge");
         rd_chk(REG_INPUT, "dual read");
         wr(REG_INPUT, 32'h0000F000);
         rd_chk(REG_STATUS, "req drop");
      end
      rd_chk(REG_IRQ_STAT, "irq_stat");
      wr(REG_IRQ_STAT, 32'h1);
      rd_chk(REG_IRQ_STAT, "irq_stat");
      give_verdict;
   end
endmodule
`undef CHK
`default_nettype wire
